/* File: core/skl_defs.svh */
// register offsets, field positions, encodings and reset values of the key
// and lifecycle controller; included by the package, the controller and the bench
`ifndef SKL_DEFS_SVH
`define SKL_DEFS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define SKL_OFS_ENABLE 8'h00
`define SKL_OFS_LIFECYCLE 8'h04
`define SKL_OFS_FIXED_LOCK 8'h08
`define SKL_OFS_KEY_SEL 8'h0C
`define SKL_OFS_ROOT_KEY0 8'h10
`define SKL_ROOT_PAGE 4'h1

// ************************************************************
// field positions
// ************************************************************
`define SKL_ENABLE_BIT 0
`define SKL_LC_FIELD_MSB 3
`define SKL_LC_VALID_BIT 8
`define SKL_KEY_SEL_MSB 1

// ************************************************************
// encodings
// ************************************************************
`define SKL_LCS_DEBUG 4'h0
`define SKL_LCS_SECURE 4'h2
`define SKL_KSEL_FIXED 2'h0
`define SKL_KSEL_ROOT 2'h1
`define SKL_KSEL_SESSION 2'h2

// ************************************************************
// reset values
// ************************************************************
`define SKL_RST_ENABLE 1'h0
`define SKL_RST_KEY_SEL 2'h2
`define SKL_RST_LOCK 1'h0

`endif

/* File: core/skl_pkg.sv */
// types shared by the key and lifecycle controller
// assumes skl_defs.svh sits on the include path
`include "skl_defs.svh"

package skl_pkg;

   // lifecycle progress, one-hot
   typedef enum logic [2:0] {
      SKL_LC_UNCONFIG = 3'b001,
      SKL_LC_DEBUG = 3'b010,
      SKL_LC_SECURE = 3'b100
   } skl_lc_t;

   // key routed to the cipher engine
   typedef enum logic [1:0] {
      SKL_SEL_FIXED = `SKL_KSEL_FIXED,
      SKL_SEL_ROOT = `SKL_KSEL_ROOT,
      SKL_SEL_SESSION = `SKL_KSEL_SESSION
   } skl_key_sel_t;

endpackage

/* File: core/skl_key_mux.sv */
// registered key selector in front of the cipher engine
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module skl_key_mux import skl_pkg::*; #(
   parameter int KEY_W = 128,
   // hard-wired design key; value arbitrary
   parameter logic [KEY_W-1:0] FIXED_KEY = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [1:0] key_sel,
   input wire logic fixed_lock,
   input wire logic [KEY_W-1:0] root_key,
   input wire logic [KEY_W-1:0] session_key,
   output logic [KEY_W-1:0] cipher_key
);

   // ************************************************************
   // selection
   // ************************************************************
   wire logic pick_fixed;
   wire logic [KEY_W-1:0] next_cipher_key;

   assign pick_fixed = (key_sel == SKL_SEL_FIXED) && !fixed_lock;
   assign next_cipher_key = pick_fixed ? FIXED_KEY :
                            (key_sel == SKL_SEL_ROOT) ? root_key :
                            (key_sel == SKL_SEL_SESSION) ? session_key :
                            '0;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cipher_key <= '0;
      end else begin
         cipher_key <= next_cipher_key;
      end
   end

endmodule

`default_nettype wire

/* File: core/skl_lifecycle_ctrl.sv */
// key and lifecycle controller: register port, lifecycle, root key store,
// fixed key lock and key selection for the cipher engine
// assumes a single clock, synchronous register strobes, async active-low reset
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

`include "skl_defs.svh"

module skl_lifecycle_ctrl import skl_pkg::*; #(
   parameter int KEY_W = 128,
   parameter int WORDS = 4
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic [KEY_W-1:0] SESSION_KEY,
   output logic [KEY_W-1:0] CIPHER_KEY,
   output logic SUBSYS_ENABLE,
   output logic IDLE_ALLOWED,
   output logic LC_DEBUG_MODE,
   output logic LC_SECURE_MODE,
   output logic FIXED_KEY_LOCKED
);

   // ************************************************************
   // address decode
   // ************************************************************
   wire logic wr_enable;
   wire logic wr_lc;
   wire logic wr_lock;
   wire logic wr_sel;
   wire logic hit_root;
   wire logic wr_root;
   wire logic [1:0] root_idx;

   assign wr_enable = WR && (ADDR == `SKL_OFS_ENABLE);
   assign wr_lc = WR && (ADDR == `SKL_OFS_LIFECYCLE);
   assign wr_lock = WR && (ADDR == `SKL_OFS_FIXED_LOCK);
   assign wr_sel = WR && (ADDR == `SKL_OFS_KEY_SEL);
   assign hit_root = (ADDR[7:4] == `SKL_ROOT_PAGE) && (ADDR[1:0] == 2'h0);
   assign wr_root = WR && hit_root;
   assign root_idx = ADDR[3:2];

   // ************************************************************
   // subsystem enable and idle permission
   // ************************************************************
   logic next_enable;

   assign next_enable = wr_enable ? WDATA[`SKL_ENABLE_BIT] : SUBSYS_ENABLE;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         SUBSYS_ENABLE <= `SKL_RST_ENABLE;
         IDLE_ALLOWED <= 1'h1;
      end else begin
         SUBSYS_ENABLE <= next_enable;
         IDLE_ALLOWED <= !next_enable;
      end
   end

   // ************************************************************
   // lifecycle state
   // ************************************************************
   skl_lc_t lc_state;
   skl_lc_t next_lc_state;
   wire logic [3:0] lc_wdata;
   wire logic lc_legal;
   wire logic lc_valid;
   wire logic [3:0] lc_field;

   assign lc_wdata = WDATA[`SKL_LC_FIELD_MSB:0];
   assign lc_legal = (lc_wdata == `SKL_LCS_DEBUG) || (lc_wdata == `SKL_LCS_SECURE);
   assign lc_valid = (lc_state != SKL_LC_UNCONFIG);
   // unconfigured reads as secure
   assign lc_field = (lc_state == SKL_LC_DEBUG) ? `SKL_LCS_DEBUG : `SKL_LCS_SECURE;

   always_comb begin
      next_lc_state = lc_state;
      case (lc_state)
         SKL_LC_UNCONFIG: begin
            if (wr_lc && lc_legal) begin
               next_lc_state = (lc_wdata == `SKL_LCS_DEBUG) ? SKL_LC_DEBUG : SKL_LC_SECURE;
            end
         end
         SKL_LC_DEBUG: begin
            next_lc_state = SKL_LC_DEBUG;
         end
         SKL_LC_SECURE: begin
            next_lc_state = SKL_LC_SECURE;
         end
         default: begin
            next_lc_state = SKL_LC_UNCONFIG;
         end
      endcase
   end

   // held regardless of enable; only reset clears it
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         lc_state <= SKL_LC_UNCONFIG;
         LC_DEBUG_MODE <= 1'h0;
         LC_SECURE_MODE <= 1'h0;
      end else begin
         lc_state <= next_lc_state;
         LC_DEBUG_MODE <= (next_lc_state == SKL_LC_DEBUG);
         LC_SECURE_MODE <= (next_lc_state == SKL_LC_SECURE);
      end
   end

   // ************************************************************
   // fixed key lock and key select
   // ************************************************************
   logic [1:0] key_sel;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         FIXED_KEY_LOCKED <= `SKL_RST_LOCK;
         key_sel <= `SKL_RST_KEY_SEL;
      end else begin
         FIXED_KEY_LOCKED <= FIXED_KEY_LOCKED || wr_lock;
         key_sel <= wr_sel ? WDATA[`SKL_KEY_SEL_MSB:0] : key_sel;
      end
   end

   // ************************************************************
   // root key store
   // ************************************************************
   logic [31:0] root_word [0:WORDS-1];
   logic [WORDS-1:0] root_written;
   wire logic [WORDS-1:0] root_accept;
   wire logic [KEY_W-1:0] root_key;
   wire logic root_retained;

   genvar gi;
   generate
      for (gi = 0; gi < WORDS; gi = gi + 1) begin : g_root
         // ignored until a lifecycle is configured
         assign root_accept[gi] = wr_root && (root_idx == 2'(gi)) &&
                                  ((lc_state == SKL_LC_DEBUG) ||
                                   ((lc_state == SKL_LC_SECURE) && !root_written[gi]));
         assign root_key[gi*32 +: 32] = root_word[gi];

         always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
               root_word[gi] <= 32'h00000000;
               root_written[gi] <= 1'h0;
            end else begin
               if (root_accept[gi]) begin
                  root_word[gi] <= WDATA;
                  root_written[gi] <= 1'h1;
               end
            end
         end
      end
   endgenerate

   assign root_retained = &root_written;

   // ************************************************************
   // cipher key routing
   // ************************************************************
   skl_key_mux #(
      .KEY_W(KEY_W)
   ) u_key_mux (
      .clk(CLK),
      .resetn(RESETN),
      .key_sel(key_sel),
      .fixed_lock(FIXED_KEY_LOCKED),
      .root_key(root_key),
      .session_key(SESSION_KEY),
      .cipher_key(CIPHER_KEY)
   );

   // ************************************************************
   // read path
   // ************************************************************
   wire logic [31:0] rd_enable;
   wire logic [31:0] rd_lc;
   wire logic [31:0] rd_lock;
   wire logic [31:0] rd_sel;
   wire logic [31:0] rd_root0;
   wire logic [31:0] next_rdata;

   assign rd_enable = {31'h00000000, SUBSYS_ENABLE};
   assign rd_lc = {23'h000000, lc_valid, 4'h0, lc_field};
   assign rd_lock = {31'h00000000, FIXED_KEY_LOCKED};
   assign rd_sel = {30'h00000000, key_sel};
   // key words never read back; word zero shows retention only
   assign rd_root0 = {31'h00000000, root_retained};
   assign next_rdata = !RD ? 32'h00000000 :
                       (ADDR == `SKL_OFS_ENABLE) ? rd_enable :
                       (ADDR == `SKL_OFS_LIFECYCLE) ? rd_lc :
                       (ADDR == `SKL_OFS_FIXED_LOCK) ? rd_lock :
                       (ADDR == `SKL_OFS_KEY_SEL) ? rd_sel :
                       (ADDR == `SKL_OFS_ROOT_KEY0) ? rd_root0 :
                       32'h00000000;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         RDATA <= 32'h00000000;
      end else begin
         RDATA <= next_rdata;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);

   sequence s_lc_legal_write;
      wr_lc && lc_legal && (lc_state == SKL_LC_UNCONFIG);
   endsequence

   sequence s_root0_write;
      WR && (ADDR == `SKL_OFS_ROOT_KEY0);
   endsequence

   sequence s_lock_write;
      wr_lock;
   endsequence

   AST_LC_RESET_READ: assert property (
      (RD && (ADDR == `SKL_OFS_LIFECYCLE) && (lc_state == SKL_LC_UNCONFIG))
      |=> (RDATA == {28'h0000000, `SKL_LCS_SECURE}))
      else $error("unconfigured lifecycle did not read secure and invalid");

   AST_LC_BECOMES_VALID: assert property (
      s_lc_legal_write |=> lc_valid ##1 lc_valid)
      else $error("legal lifecycle write did not make the flag valid");

   AST_LC_MODE_MATCH: assert property (
      s_lc_legal_write |=> ##1 (LC_DEBUG_MODE == ($past(lc_wdata, 2) == `SKL_LCS_DEBUG)))
      else $error("lifecycle mode does not match the written encoding");

   AST_LC_ILLEGAL_IGNORED: assert property (
      (wr_lc && !lc_legal && !lc_valid) |=> !lc_valid)
      else $error("illegal lifecycle value made the flag valid");

   AST_SECURE_WRITE_ONCE: assert property (
      (s_root0_write and (lc_state == SKL_LC_SECURE) && root_written[0])
      |=> $stable(root_word[0]))
      else $error("second root key write accepted in secure lifecycle");

   AST_DEBUG_REWRITE: assert property (
      (s_root0_write and (lc_state == SKL_LC_DEBUG))
      |=> (root_word[0] == $past(WDATA)))
      else $error("root key write refused in debug lifecycle");

   AST_LOCK_STICKY: assert property (
      s_lock_write |=> FIXED_KEY_LOCKED [*8])
      else $error("fixed key lock did not hold");

   AST_LOCKED_ZERO: assert property (
      ((key_sel == SKL_SEL_FIXED) && FIXED_KEY_LOCKED) |=> (CIPHER_KEY == '0))
      else $error("locked fixed key reached the cipher engine");

   AST_ROOT_ROUTE: assert property (
      (key_sel == SKL_SEL_ROOT) |=> (CIPHER_KEY == $past(root_key)))
      else $error("root key not routed when selected");

   AST_RETAIN_READ: assert property (
      (RD && (ADDR == `SKL_OFS_ROOT_KEY0))
      |=> (RDATA == {31'h00000000, $past(root_retained)}))
      else $error("root key word zero does not show retention");

   AST_KEY_HIDDEN: assert property (
      (RD && hit_root && (root_idx != 2'h0)) |=> (RDATA == 32'h00000000))
      else $error("root key word readable");

   AST_IDLE_BLOCKED: assert property (
      SUBSYS_ENABLE |-> !IDLE_ALLOWED)
      else $error("idle allowed while subsystem enabled");

   AST_DISABLE_KEEPS: assert property (
      (wr_enable && !WDATA[`SKL_ENABLE_BIT]) |=> $stable(root_key) && $stable(lc_state))
      else $error("disable disturbed retained state");

   sequence s_root_write_unconfig;
      wr_root && (lc_state == SKL_LC_UNCONFIG);
   endsequence

   AST_RESET_CLEARS: assert property (
      $rose(RESETN) |-> (lc_state == SKL_LC_UNCONFIG) && (root_key == '0) &&
                        (root_written == '0) && !FIXED_KEY_LOCKED)
      else $error("reset left retained state behind");

   AST_ROOT_UNCONFIG_IGNORED: assert property (
      s_root_write_unconfig |=> $stable(root_written) && $stable(root_key))
      else $error("root key write accepted before lifecycle was valid");

   AST_LC_WRITE_ONCE: assert property (
      (wr_lc && lc_valid) |=> $stable(lc_state))
      else $error("configured lifecycle changed by a later write");

   AST_SESSION_ROUTE: assert property (
      (key_sel == SKL_SEL_SESSION) |=> (CIPHER_KEY == $past(SESSION_KEY)))
      else $error("session key not routed when selected");

   AST_BAD_SEL_ZERO: assert property (
      (key_sel == 2'h3) |=> (CIPHER_KEY == '0))
      else $error("unused key select did not give a zero key");

   AST_RDATA_QUIET: assert property (
      !RD |=> (RDATA == 32'h00000000))
      else $error("read data shown without a read");

   AST_ENABLE_FOLLOWS: assert property (
      wr_enable |=> (SUBSYS_ENABLE == $past(WDATA[`SKL_ENABLE_BIT])) &&
                    (IDLE_ALLOWED == !$past(WDATA[`SKL_ENABLE_BIT])))
      else $error("enable write not reflected in enable and idle outputs");

   AST_LOCK_NEVER_FALLS: assert property (
      FIXED_KEY_LOCKED |=> FIXED_KEY_LOCKED)
      else $error("fixed key lock released without reset");

   AST_LC_FLAGS_MATCH: assert property (
      (LC_SECURE_MODE == (lc_state == SKL_LC_SECURE)) &&
      (LC_DEBUG_MODE == (lc_state == SKL_LC_DEBUG)))
      else $error("lifecycle mode outputs disagree with lifecycle state");

   AST_SECURE_FIRST_WRITE: assert property (
      (s_root0_write and (lc_state == SKL_LC_SECURE) && !root_written[0])
      |=> (root_word[0] == $past(WDATA)))
      else $error("first root key write refused in secure lifecycle");

   AST_VALID_READ: assert property (
      (RD && (ADDR == `SKL_OFS_LIFECYCLE) && lc_valid) |=> RDATA[`SKL_LC_VALID_BIT])
      else $error("configured lifecycle did not read valid");

endmodule

`default_nettype wire

/* File: tb/skl_lifecycle_ctrl_tb.sv */
// self-checking bench for the key and lifecycle controller
// assumes skl_pkg and skl_defs.svh are compiled first; drives the register port itself
`timescale 1ns/1ps
`default_nettype none

`include "skl_defs.svh"

module skl_lifecycle_ctrl_tb import skl_pkg::*;;
   logic CLK = 1'b0;
   logic RESETN = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic [31:0] RDATA;
   logic [127:0] SESSION_KEY = 128'hA5A5A5A55A5A5A5AC3C3C3C33C3C3C3C;
   logic [127:0] CIPHER_KEY;
   logic SUBSYS_ENABLE, IDLE_ALLOWED, LC_DEBUG_MODE, LC_SECURE_MODE, FIXED_KEY_LOCKED;
   int n_errors = 0;
   int cmp_count = 0;
   logic [31:0] rv;
   logic [127:0] ka = 128'h00112233445566778899AABBCCDDEEFF;
   logic [127:0] kb = 128'hFFEEDDCCBBAA99887766554433221100;

   always #4 CLK = ~CLK;

   skl_lifecycle_ctrl DUT (
      .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .SESSION_KEY(SESSION_KEY), .CIPHER_KEY(CIPHER_KEY),
      .SUBSYS_ENABLE(SUBSYS_ENABLE), .IDLE_ALLOWED(IDLE_ALLOWED),
      .LC_DEBUG_MODE(LC_DEBUG_MODE), .LC_SECURE_MODE(LC_SECURE_MODE),
      .FIXED_KEY_LOCKED(FIXED_KEY_LOCKED)
   );

   // ************************************************************
   // bus and compare helpers
   // ************************************************************
   task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1;
      d = RDATA;
   endtask

   task automatic settle();
      repeat (3) @(posedge CLK);
      #1;
   endtask

   task automatic load_key(input logic [127:0] k);
      for (int i = 0; i < 4; i++) begin
         wr(8'h10 + 8'(4 * i), k[32*i +: 32]);
      end
   endtask

   task automatic do_reset(input int n);
      @(posedge CLK);
      RESETN <= 1'b0;
      repeat (n) @(posedge CLK);
      RESETN <= 1'b1;
      settle();
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset_state();
      rd(`SKL_OFS_LIFECYCLE, rv);
      chk(rv, 32'h2, "lc after reset");
      rd(`SKL_OFS_ROOT_KEY0, rv);
      chk(rv, 32'h0, "retained after reset");
      rd(`SKL_OFS_FIXED_LOCK, rv);
      chk(rv, 32'h0, "lock after reset");
      chk({LC_DEBUG_MODE, LC_SECURE_MODE, FIXED_KEY_LOCKED, IDLE_ALLOWED}, 4'h1, "flags");
      chk(CIPHER_KEY, SESSION_KEY, "session key at reset");
      rd(8'h40, rv);
      chk(rv, 32'h0, "unmapped read");
   endtask

   task automatic t_enable();
      wr(`SKL_OFS_ENABLE, 32'h1);
      settle();
      chk({SUBSYS_ENABLE, IDLE_ALLOWED}, 2'b10, "enabled blocks idle");
      rd(`SKL_OFS_ENABLE, rv);
      chk(rv, 32'h1, "enable readback");
   endtask

   task automatic t_secure();
      load_key(kb);
      rd(`SKL_OFS_ROOT_KEY0, rv);
      chk(rv, 32'h0, "key write before lc valid");
      wr(`SKL_OFS_LIFECYCLE, 32'h7);
      rd(`SKL_OFS_LIFECYCLE, rv);
      chk(rv, 32'h2, "illegal lc ignored");
      wr(`SKL_OFS_LIFECYCLE, {28'h0, `SKL_LCS_SECURE});
      rd(`SKL_OFS_LIFECYCLE, rv);
      chk(rv, 32'h102, "secure valid");
      chk(LC_SECURE_MODE, 1'b1, "secure mode flag");
      wr(`SKL_OFS_LIFECYCLE, {28'h0, `SKL_LCS_DEBUG});
      rd(`SKL_OFS_LIFECYCLE, rv);
      chk(rv, 32'h102, "lc write once");
      load_key(ka);
      rd(`SKL_OFS_ROOT_KEY0, rv);
      chk(rv, 32'h1, "retained");
      rd(8'h14, rv);
      chk(rv, 32'h0, "key word not readable");
      load_key(kb);
      wr(`SKL_OFS_KEY_SEL, {30'h0, `SKL_KSEL_ROOT});
      settle();
      chk(CIPHER_KEY, ka, "secure keeps first key");
      wr(`SKL_OFS_ENABLE, 32'h0);
      settle();
      chk(IDLE_ALLOWED, 1'b1, "idle allowed once disabled");
      chk(CIPHER_KEY, ka, "key kept while disabled");
      rd(`SKL_OFS_LIFECYCLE, rv);
      chk(rv, 32'h102, "lifecycle kept while disabled");
   endtask

   task automatic t_fixed();
      wr(`SKL_OFS_KEY_SEL, {30'h0, `SKL_KSEL_FIXED});
      settle();
      chk(CIPHER_KEY == 128'h0 || CIPHER_KEY == SESSION_KEY, 1'b0, "fixed key used");
      rd(`SKL_OFS_KEY_SEL, rv);
      chk(rv, 32'h0, "select readback");
      wr(`SKL_OFS_FIXED_LOCK, 32'h0);
      settle();
      chk(FIXED_KEY_LOCKED, 1'b1, "lock flag set");
      chk(CIPHER_KEY, 128'h0, "locked fixed gives zero");
      rd(`SKL_OFS_FIXED_LOCK, rv);
      chk(rv, 32'h1, "lock readback");
      wr(`SKL_OFS_KEY_SEL, {30'h0, `SKL_KSEL_SESSION});
      @(posedge CLK);
      SESSION_KEY <= kb;
      settle();
      chk(CIPHER_KEY, kb, "session routed");
      wr(`SKL_OFS_KEY_SEL, {30'h0, `SKL_KSEL_FIXED});
      settle();
      chk(CIPHER_KEY, 128'h0, "lock persists");
   endtask

   task automatic t_debug_after_reset();
      do_reset(3);
      chk({FIXED_KEY_LOCKED, LC_SECURE_MODE}, 2'b00, "reset clears flags");
      chk(CIPHER_KEY, kb, "select back to session");
      rd(`SKL_OFS_ROOT_KEY0, rv);
      chk(rv, 32'h0, "key cleared");
      wr(`SKL_OFS_LIFECYCLE, {28'h0, `SKL_LCS_DEBUG});
      rd(`SKL_OFS_LIFECYCLE, rv);
      chk(rv, 32'h100, "debug valid");
      chk(LC_DEBUG_MODE, 1'b1, "debug mode flag");
      load_key(ka);
      load_key(kb);
      wr(`SKL_OFS_KEY_SEL, {30'h0, `SKL_KSEL_ROOT});
      settle();
      chk(CIPHER_KEY, kb, "debug rewrites key");
      rd(`SKL_OFS_ROOT_KEY0, rv);
      chk(rv, 32'h1, "retained in debug");
      wr(`SKL_OFS_KEY_SEL, 32'h3);
      settle();
      chk(CIPHER_KEY, 128'h0, "unused select gives zero");
      wr(`SKL_OFS_KEY_SEL, {30'h0, `SKL_KSEL_FIXED});
      settle();
      chk(CIPHER_KEY == 128'h0, 1'b0, "fixed usable after reset");
   endtask

   // ************************************************************
   // run control
   // ************************************************************
   task automatic final_report();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #200000;
      n_errors++;
      final_report();
   end

   initial begin
      repeat (20) @(posedge CLK);
      RESETN <= 1'b1;
      settle();
      t_reset_state();
      t_enable();
      t_secure();
      t_fixed();
      t_debug_after_reset();
      final_report();
   end
endmodule

`default_nettype wire
